// file: verilog/temp_alarm_pkg.sv
/*
  constants for the temperature alarm logic: widths, reset values, status bit positions.
  assumes a single 25 MHz clock domain and a synchronous active-high reset.
*/
package temp_alarm_pkg;
  // ----------------------------------------
  // data widths
  // ----------------------------------------
  localparam int TEMP_W = 10;
  localparam int HYST_W = 8;
  localparam int OFFS_W = 10;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [HYST_W-1:0] HYST_RESET = 8'h0A;
  // ----------------------------------------
  // status bit positions
  // ----------------------------------------
  localparam int ST_W = 8;
  localparam int ST_LOCAL_LOW = 0;
  localparam int ST_REMOTE_OPEN = 2;
  localparam int ST_REMOTE_LOW = 3;
  localparam int ST_REMOTE_HIGH = 4;
  localparam int ST_LOCAL_LOW2 = 5;
  localparam int ST_LOCAL_HIGH = 6;
  // ----------------------------------------
  // alert response address (seven bits)
  // ----------------------------------------
  localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;
  typedef enum logic {CH_LOCAL, CH_REMOTE} channel_e;
endpackage

// file: verilog/temperature_alarm_logic.sv
/*
  alarm, trip and fault-flag logic of a two-channel temperature monitor.
  assumes an external converter presents one result per channel with a done pulse,
  an external serial interface reports alert-response reads and status clears,
  and open-drain pads resolve the *_oe outputs (oe high pulls the line low).
*/
`timescale 1ns/10ps
// Behaviour
// - open-diode comparator is sampled only when a conversion starts
// - detected open diode sets status bit 2
// - open flag pulls alarm low when pin acts as alarm
// - alarm on temperature above high limit or at/below low limit
// - alarm mask keeps the pin released regardless of causes
// - primary trip low when either channel exceeds its trip limit
// - primary trip has no mask
// - trip releases at limit minus hysteresis, without host action
// - hysteresis loads ten degrees at reset, reprogrammable later
// - hysteresis is unsigned whole degrees, one per bit
// - one hysteresis value serves both channels
// - shared pin selects alarm or second trip function
// - second trip low when either channel exceeds its high limit
// - second trip self-releases like primary trip, not maskable
// - hysteresis also sets second trip release point
// - signed offset is added to remote measurement
// - both channels OR into primary and second trip
// - alert-response read answered with own seven-bit address 0x0C
// - lowest address wins arbitration; losers keep alarm asserted
module temperature_alarm_logic
  import temp_alarm_pkg::*;
#(
  parameter int TW = TEMP_W
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic conv_start,
  input wire logic remote_open_cmp,
  input wire logic result_done,
  input wire temp_alarm_pkg::channel_e result_channel,
  input wire logic signed [TW-1:0] result_temp,
  input wire logic signed [OFFS_W-1:0] remote_offset,
  input wire logic signed [TW-1:0] local_high_limit,
  input wire logic signed [TW-1:0] local_low_limit,
  input wire logic signed [TW-1:0] local_trip_limit,
  input wire logic signed [TW-1:0] remote_high_limit,
  input wire logic signed [TW-1:0] remote_low_limit,
  input wire logic signed [TW-1:0] remote_trip_limit,
  input wire logic hyst_write,
  input wire logic [HYST_W-1:0] hyst_wdata,
  input wire logic alarm_mask,
  input wire logic pin_as_second_trip,
  input wire logic status_clear,
  input wire logic alert_resp_read,
  input wire logic arb_lost,
  output logic [HYST_W-1:0] hysteresis,
  output logic [ST_W-1:0] status,
  output logic signed [TW-1:0] local_temp,
  output logic signed [TW-1:0] remote_temp,
  output logic alert_resp_ack,
  output logic [6:0] alert_resp_match,
  output logic failsafe_trip_oe,
  output logic shared_alarm_pin_oe
);
  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (TW < HYST_W + 1 || TW < OFFS_W)
  begin : g_bad_width
    $error("temperature width too narrow for hysteresis or offset");
  end
  if (ST_W <= ST_LOCAL_HIGH)
  begin : g_bad_status
    $error("status register too narrow for its flag positions");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic open_seen_r;
  logic [2:0] open_sync_r;
  logic open_level_r;
  logic [HYST_W-1:0] hyst_r;
  logic [ST_W-1:0] status_r;
  logic signed [TW-1:0] local_r;
  logic signed [TW-1:0] remote_r;
  logic trip_local_r;
  logic trip_remote_r;
  logic trip2_local_r;
  logic trip2_remote_r;
  logic alarm_r;
  logic serviced_r;
  logic ack_r;
  logic signed [TW:0] adj_temp;
  logic [ST_W-1:0] cause_bits;
  logic alarm_cause;

  // hysteresis hysteresis-adjusted release test, widened to avoid wrap near full scale
  function automatic logic next_trip(input logic cur, input logic signed [TW-1:0] t,
                                     input logic signed [TW-1:0] lim, input logic [HYST_W-1:0] h);
    logic signed [TW+1:0] rel;
    rel = $signed({{2{lim[TW-1]}}, lim}) - $signed({{(TW+2-HYST_W){1'b0}}, h});
    if ($signed({{2{t[TW-1]}}, t}) > $signed({{2{lim[TW-1]}}, lim}))
    begin
      next_trip = 1'b1;
    end
    else if ($signed({{2{t[TW-1]}}, t}) <= rel)
    begin
      next_trip = 1'b0;
    end
    else
    begin
      next_trip = cur;
    end
  endfunction

  // limit decode shared by the status flags and the alarm release test: {above high, at or below low}
  function automatic logic [1:0] limit_hits(input logic signed [TW-1:0] t, input logic signed [TW-1:0] hi,
                                            input logic signed [TW-1:0] lo);
    limit_hits = {t > hi, t <= lo};
  endfunction

  // offset-corrected remote reading, one bit wider; saturated to the result range where it is used
  always_comb
  begin
    adj_temp = $signed({result_temp[TW-1], result_temp}) +
               $signed({{(TW+1-OFFS_W){remote_offset[OFFS_W-1]}}, remote_offset});
  end

  // ----------------------------------------
  // open-diode filter and sampling
  // ----------------------------------------
  // the comparator is analog and free-running, so it is filtered before the sample point
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      open_sync_r <= 3'h0;
      open_level_r <= 1'b0;
    end
    else
    begin
      open_sync_r <= {open_sync_r[1:0], remote_open_cmp};
      if (open_sync_r[2] == open_sync_r[1])
      begin
        open_level_r <= open_sync_r[2];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      open_seen_r <= 1'b0;
    end
    else if (conv_start)
    begin
      open_seen_r <= open_level_r;
    end
  end

  // ----------------------------------------
  // hysteresis register
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      hyst_r <= HYST_RESET;
    end
    else if (hyst_write)
    begin
      hyst_r <= hyst_wdata;
    end
  end

  // ----------------------------------------
  // latest readings
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      local_r <= '0;
      remote_r <= '0;
    end
    else if (result_done)
    begin
      if (result_channel == CH_LOCAL)
      begin
        local_r <= result_temp;
      end
      else if (adj_temp > $signed({1'b0, {(TW-1){1'b1}}}))
      begin
        remote_r <= {1'b0, {(TW-1){1'b1}}};
      end
      else if (adj_temp < $signed({1'b1, 1'b1, {(TW-1){1'b0}}}))
      begin
        remote_r <= {1'b1, {(TW-1){1'b0}}};
      end
      else
      begin
        remote_r <= adj_temp[TW-1:0];
      end
    end
  end

  // ----------------------------------------
  // trip comparators, one hysteresis for all
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      trip_local_r <= 1'b0;
      trip_remote_r <= 1'b0;
      trip2_local_r <= 1'b0;
      trip2_remote_r <= 1'b0;
    end
    else if (result_done)
    begin
      if (result_channel == CH_LOCAL)
      begin
        trip_local_r <= next_trip(trip_local_r, result_temp, local_trip_limit, hyst_r);
        trip2_local_r <= next_trip(trip2_local_r, result_temp, local_high_limit, hyst_r);
      end
      else
      begin
        trip_remote_r <= next_trip(trip_remote_r, remote_temp_sat(adj_temp), remote_trip_limit, hyst_r);
        trip2_remote_r <= next_trip(trip2_remote_r, remote_temp_sat(adj_temp), remote_high_limit, hyst_r);
      end
    end
  end

  function automatic logic signed [TW-1:0] remote_temp_sat(input logic signed [TW:0] v);
    if (v > $signed({1'b0, {(TW-1){1'b1}}}))
    begin
      remote_temp_sat = {1'b0, {(TW-1){1'b1}}};
    end
    else if (v < $signed({1'b1, 1'b1, {(TW-1){1'b0}}}))
    begin
      remote_temp_sat = {1'b1, {(TW-1){1'b0}}};
    end
    else
    begin
      remote_temp_sat = v[TW-1:0];
    end
  endfunction

  // ----------------------------------------
  // status flags: sticky, a new cause beats a clear
  // ----------------------------------------
  always_comb
  begin
    cause_bits = '0;
    if (result_done && result_channel == CH_LOCAL)
    begin
      {cause_bits[ST_LOCAL_HIGH], cause_bits[ST_LOCAL_LOW]} =
        limit_hits(result_temp, local_high_limit, local_low_limit);
    end
    if (result_done && result_channel == CH_REMOTE)
    begin
      {cause_bits[ST_REMOTE_HIGH], cause_bits[ST_REMOTE_LOW]} =
        limit_hits(remote_temp_sat(adj_temp), remote_high_limit, remote_low_limit);
      cause_bits[ST_REMOTE_OPEN] = open_seen_r;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      status_r <= '0;
    end
    else if (status_clear)
    begin
      status_r <= cause_bits;
    end
    else
    begin
      status_r <= status_r | cause_bits;
    end
  end

  // ----------------------------------------
  // alarm latch and alert-response servicing
  // ----------------------------------------
  // the pin holds until serviced; a losing bidder is not serviced and keeps it low
  assign alarm_cause = (|limit_hits(local_r, local_high_limit, local_low_limit)) ||
                       (|limit_hits(remote_r, remote_high_limit, remote_low_limit)) || open_seen_r;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      serviced_r <= 1'b0;
      ack_r <= 1'b0;
    end
    else
    begin
      ack_r <= alert_resp_read && alarm_r && !pin_as_second_trip;
      if (|cause_bits)
      begin
        serviced_r <= 1'b0;
      end
      else if (ack_r && !arb_lost)
      begin
        serviced_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      alarm_r <= 1'b0;
    end
    else if (|cause_bits)
    begin
      alarm_r <= 1'b1;
    end
    else if (serviced_r && !alarm_cause && status_r == '0)
    begin
      alarm_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign hysteresis = hyst_r;
  assign status = status_r;
  assign local_temp = local_r;
  assign remote_temp = remote_r;
  assign alert_resp_ack = ack_r;
  assign alert_resp_match = ALERT_RESP_ADDR;
  assign failsafe_trip_oe = trip_local_r || trip_remote_r;
  assign shared_alarm_pin_oe = pin_as_second_trip ? (trip2_local_r || trip2_remote_r)
                                                  : (alarm_r && !alarm_mask);
endmodule

// file: sim/temperature_alarm_logic_monitor.sv
/*
  assertion checker for the temperature alarm logic, bound to its top ports.
  assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module temperature_alarm_logic_monitor
  import temp_alarm_pkg::*;
#(
  parameter int TW = TEMP_W
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic conv_start,
  input wire logic remote_open_cmp,
  input wire logic result_done,
  input wire temp_alarm_pkg::channel_e result_channel,
  input wire logic signed [TW-1:0] result_temp,
  input wire logic signed [TW-1:0] local_high_limit,
  input wire logic signed [TW-1:0] local_trip_limit,
  input wire logic alarm_mask,
  input wire logic pin_as_second_trip,
  input wire logic [ST_W-1:0] status,
  input wire logic failsafe_trip_oe,
  input wire logic shared_alarm_pin_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // temperature checks on the local channel only: remote results pass an offset adder the checker cannot see
  wire loc_res = result_done && result_channel == CH_LOCAL;
  wire rem_res = result_done && result_channel == CH_REMOTE;
  // expected open sample: three-stage filter on the comparator, taken when a conversion starts
  logic [2:0] cmp_hist_r;
  logic cmp_level_r;
  logic open_ref_r;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cmp_hist_r <= 3'h0;
      cmp_level_r <= 1'b0;
      open_ref_r <= 1'b0;
    end
    else
    begin
      cmp_hist_r <= {cmp_hist_r[1:0], remote_open_cmp};
      if (cmp_hist_r[2] == cmp_hist_r[1])
      begin
        cmp_level_r <= cmp_hist_r[1];
      end
      if (conv_start)
      begin
        open_ref_r <= cmp_level_r;
      end
    end
  end
  property p_open_set;
    rem_res && open_ref_r |=> status[ST_REMOTE_OPEN];
  endproperty
  a_open_set: assert property (p_open_set) else $error("open flag not set");
  property p_open_only;
    $rose(status[ST_REMOTE_OPEN]) |-> $past(rem_res && open_ref_r);
  endproperty
  a_open_only: assert property (p_open_only) else $error("open flag without sample");
  property p_trip_set;
    loc_res && result_temp > local_trip_limit |=> failsafe_trip_oe;
  endproperty
  a_trip_set: assert property (p_trip_set) else $error("trip not driven");
  property p_trip_fall;
    $fell(failsafe_trip_oe) |-> $past(result_done || reset);
  endproperty
  a_trip_fall: assert property (p_trip_fall) else $error("trip released without result");
  property p_high_flag;
    loc_res && result_temp > local_high_limit |=> status[ST_LOCAL_HIGH];
  endproperty
  a_high_flag: assert property (p_high_flag) else $error("high flag missing");
  property p_alarm_on;
    !alarm_mask && !pin_as_second_trip && loc_res && result_temp > local_high_limit
      |=> alarm_mask || pin_as_second_trip || shared_alarm_pin_oe;
  endproperty
  a_alarm_on: assert property (p_alarm_on) else $error("alarm not driven");
  property p_trip2;
    pin_as_second_trip && loc_res && result_temp > local_high_limit |=> !pin_as_second_trip || shared_alarm_pin_oe;
  endproperty
  a_trip2: assert property (p_trip2) else $error("second trip not driven");
  property p_mask;
    alarm_mask && $past(alarm_mask) && !pin_as_second_trip && !$past(pin_as_second_trip) |-> !shared_alarm_pin_oe;
  endproperty
  a_mask: assert property (p_mask) else $error("masked alarm driven");
endmodule
bind temperature_alarm_logic temperature_alarm_logic_monitor #(.TW(TW)) temperature_alarm_logic_monitor_i (
  .clk(clk), .reset(reset), .conv_start(conv_start), .remote_open_cmp(remote_open_cmp), .result_done(result_done),
  .result_channel(result_channel), .result_temp(result_temp), .local_high_limit(local_high_limit),
  .local_trip_limit(local_trip_limit), .alarm_mask(alarm_mask), .pin_as_second_trip(pin_as_second_trip),
  .status(status), .failsafe_trip_oe(failsafe_trip_oe), .shared_alarm_pin_oe(shared_alarm_pin_oe));

// file: sim/smbus_alert_host.sv
/*
  behavioural smbus host that services the shared alert line.
  assumes the address decode sits outside the block and arrives as one read pulse.
*/
`timescale 1ns/10ps
module smbus_alert_host
(
  input wire logic clk,
  input wire logic reset,
  input wire logic alert_line,
  input wire logic enable,
  input wire logic lose,
  input wire logic alert_resp_ack,
  output logic alert_resp_read,
  output logic arb_lost,
  output logic done
);
  logic [2:0] step_r;
  // stalls at step 3 until acked, so a missing ack shows up in the bench as a failed done check after 20 cycles
  always_ff @(posedge clk)
  begin
    if (reset || !enable || alert_line)
      step_r <= 3'h0;
    else if (step_r != 3'h7 && (step_r != 3'h3 || alert_resp_ack))
      step_r <= step_r + 3'h1;
  end
  assign alert_resp_read = step_r == 3'h2;
  assign arb_lost = lose && (step_r == 3'h3 || step_r == 3'h4);
  assign done = step_r == 3'h4;
endmodule

// file: sim/temperature_alarm_logic_tb.sv
/*
  self-checking bench for the temperature alarm logic with an smbus host model.
  assumes the package, the design, the checker and the host model are compiled first.
*/
`timescale 1ns/10ps
module temperature_alarm_logic_tb;
  import temp_alarm_pkg::*;
  logic clk, reset = 1'b1, conv_start = 1'b0, remote_open_cmp = 1'b0, result_done = 1'b0, hyst_write = 1'b0;
  logic alarm_mask = 1'b1, pin_as_second_trip = 1'b0, status_clear = 1'b0, enable = 1'b0, lose = 1'b0;
  logic alert_resp_read, arb_lost, done, alert_resp_ack, failsafe_trip_oe, shared_alarm_pin_oe;
  channel_e result_channel = CH_LOCAL;
  logic signed [TEMP_W-1:0] result_temp = 10'h000, local_temp, remote_temp;
  logic signed [OFFS_W-1:0] remote_offset = 10'h000;
  // trip limits kept at or above the high limits, as the host must
  logic signed [TEMP_W-1:0] lhi = 10'h032, llo = 10'h000, ltr = 10'h050;
  logic signed [TEMP_W-1:0] rhi = 10'h03C, rlo = 10'h3EC, rtr = 10'h05A;
  logic [HYST_W-1:0] hyst_wdata = 8'h03, hysteresis;
  logic [ST_W-1:0] status;
  logic [6:0] alert_resp_match;
  int failures = 0, tests_run = 0, cycles = 0;
  wire alert_line = shared_alarm_pin_oe ? 1'b0 : 1'b1;
  wire trip_line = failsafe_trip_oe ? 1'b0 : 1'b1;
  temperature_alarm_logic temperature_alarm_logic_i (.clk(clk), .reset(reset), .conv_start(conv_start),
    .remote_open_cmp(remote_open_cmp), .result_done(result_done), .result_channel(result_channel),
    .result_temp(result_temp), .remote_offset(remote_offset), .local_high_limit(lhi), .local_low_limit(llo),
    .local_trip_limit(ltr), .remote_high_limit(rhi), .remote_low_limit(rlo), .remote_trip_limit(rtr),
    .hyst_write(hyst_write), .hyst_wdata(hyst_wdata), .alarm_mask(alarm_mask), .status_clear(status_clear),
    .pin_as_second_trip(pin_as_second_trip), .alert_resp_read(alert_resp_read), .arb_lost(arb_lost),
    .hysteresis(hysteresis), .status(status), .local_temp(local_temp), .remote_temp(remote_temp),
    .alert_resp_ack(alert_resp_ack), .alert_resp_match(alert_resp_match), .failsafe_trip_oe(failsafe_trip_oe),
    .shared_alarm_pin_oe(shared_alarm_pin_oe));
  smbus_alert_host smbus_alert_host_i (.clk(clk), .reset(reset), .alert_line(alert_line), .enable(enable),
    .lose(lose), .alert_resp_ack(alert_resp_ack), .alert_resp_read(alert_resp_read), .arb_lost(arb_lost),
    .done(done));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 1000)
    begin
      failures++;
      give_verdict();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(1);
  endtask
  task automatic res(input channel_e ch, input logic signed [TEMP_W-1:0] t);
    result_channel = ch;
    result_temp = t;
    pulse(result_done);
  endtask
  task automatic chk(input logic [TEMP_W-1:0] got, input logic [TEMP_W-1:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask
  task automatic service(input logic l);
    int n;
    n = 0;
    lose = l;
    enable = 1'b1;
    while (done !== 1'b1 && n < 20)
    begin
      tick(1);
      n++;
    end
    chk(done, 1'b1, "no ack to alert read");
    tick(2);
    enable = 1'b0;
    tick(1);
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    tick(8);
    reset = 1'b0;
    chk(hysteresis, 8'h0A, "hyst reset");
    chk(status, 8'h00, "status reset");
    chk(trip_line, 1'b1, "trip idle");
    $display("test reset done");
    res(CH_LOCAL, 10'h051);
    chk(trip_line, 1'b0, "trip set");
    chk(alert_line, 1'b1, "alarm masked");
    res(CH_LOCAL, 10'h047);
    chk(trip_line, 1'b0, "trip hold");
    res(CH_LOCAL, 10'h046);
    chk(trip_line, 1'b1, "trip release");
    remote_offset = 10'h3FB;
    res(CH_REMOTE, 10'h060);
    chk(remote_temp, 10'h05B, "offset");
    chk(trip_line, 1'b0, "remote trip");
    res(CH_REMOTE, 10'h055);
    chk(trip_line, 1'b1, "remote release");
    pulse(hyst_write);
    chk(hysteresis, 8'h03, "hyst write");
    res(CH_LOCAL, 10'h051);
    res(CH_LOCAL, 10'h04E);
    chk(trip_line, 1'b0, "hyst hold");
    res(CH_LOCAL, 10'h04D);
    chk(trip_line, 1'b1, "hyst release");
    $display("test trip done");
    // remote reading to 55, at or below high minus hysteresis, so only local drives the pin next
    res(CH_REMOTE, 10'h03C);
    pin_as_second_trip = 1'b1;
    res(CH_LOCAL, 10'h033);
    chk(alert_line, 1'b0, "trip2 set");
    res(CH_LOCAL, 10'h030);
    chk(alert_line, 1'b0, "trip2 hold");
    res(CH_LOCAL, 10'h02F);
    chk(alert_line, 1'b1, "trip2 release");
    res(CH_REMOTE, 10'h042);
    chk(alert_line, 1'b0, "trip2 remote");
    res(CH_REMOTE, 10'h03E);
    chk(alert_line, 1'b1, "trip2 remote release");
    pin_as_second_trip = 1'b0;
    alarm_mask = 1'b0;
    $display("test trip2 done");
    res(CH_LOCAL, 10'h000);
    chk(status[ST_LOCAL_LOW], 1'b1, "low flag");
    res(CH_LOCAL, 10'h033);
    chk(alert_line, 1'b0, "alarm set");
    chk(alert_resp_match, 7'h0C, "response address");
    res(CH_LOCAL, 10'h014);
    pulse(status_clear);
    chk(status, 8'h00, "clear");
    chk(alert_line, 1'b0, "alarm waits");
    service(1'b1);
    chk(alert_line, 1'b0, "arbitration lost");
    service(1'b0);
    chk(alert_line, 1'b1, "alarm release");
    $display("test alarm done");
    // the comparator passes a three-flop filter, so each change is given four cycles to settle
    remote_open_cmp = 1'b1;
    tick(4);
    res(CH_REMOTE, 10'h03C);
    chk(status[ST_REMOTE_OPEN], 1'b0, "open idle");
    pulse(conv_start);
    res(CH_REMOTE, 10'h03C);
    chk(status, 8'h04, "open flag");
    chk(alert_line, 1'b0, "open alarm");
    remote_open_cmp = 1'b0;
    tick(4);
    pulse(conv_start);
    pulse(status_clear);
    service(1'b0);
    chk(alert_line, 1'b1, "open release");
    $display("test open done");
    give_verdict();
  end
endmodule
